// ---- logic/spfp_pkg.sv ----
package spfp_pkg;

	// ----------------------------------------------------------------
	// clock and base timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ  = 40;            // core_clk rate
	localparam int TICK_CYC = CLK_MHZ * 1;   // cycles in one microsecond tick

	// ----------------------------------------------------------------
	// pulse timing, in microseconds as printed
	// ----------------------------------------------------------------
	localparam int GAP_US      = 20;   // gap_time, least off time between pulses
	localparam int SHORT_US    = 20;   // short_pulse_time, least enable/address pulse
	localparam int FUSE_MIN_US = 100;  // fuse_pulse_time, least
	localparam int FUSE_TYP_US = 300;  // fuse_pulse_time, typical
	localparam int RISE_MAX_US = 20;   // slowest edge up to a level
	localparam int FALL_MAX_US = 100;  // slowest edge back to hold_level
	localparam int CLEAR_US    = 1000; // time at zero volts to clear the device

	// durations handed to the timer, in ticks
	localparam logic [15:0] PULSE_DUR = 16'(SHORT_US + RISE_MAX_US);
	localparam logic [15:0] GAP_DUR   = 16'(GAP_US + FALL_MAX_US);

	// least lengths in cycles, for the checks on the supply level
	localparam logic [15:0] PULSE_MIN_CYC = 16'(SHORT_US * TICK_CYC);
	localparam logic [15:0] GAP_MIN_CYC   = 16'(GAP_US * TICK_CYC);
	localparam logic [15:0] FUSE_MIN_CYC  = 16'(FUSE_MIN_US * TICK_CYC);

	// ----------------------------------------------------------------
	// code and address layout
	// ----------------------------------------------------------------
	localparam int          CODE_W    = 5;      // operate_point code bits
	localparam int          ADDR_W    = 6;      // bitfield address width
	localparam logic [5:0]  ADDR_LOCK = 6'h20;  // lock bit, address 32

	// ----------------------------------------------------------------
	// supply level codes driven to the pin driver
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_OFF       = 2'h0;  // about zero volts
	localparam logic [1:0] LVL_HOLD      = 2'h1;  // hold_level, 5.0 V
	localparam logic [1:0] LVL_COUNT     = 2'h2;  // count_level, 12.5 V
	localparam logic [1:0] LVL_KEY_FUSE  = 2'h3;  // key_fuse_level, 26 V

	// ----------------------------------------------------------------
	// user command modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_TRY  = 2'h0;  // provisional whole code
	localparam logic [1:0] MODE_BURN = 2'h1;  // fuse each set bit
	localparam logic [1:0] MODE_LOCK = 2'h2;  // fuse the lock bit

	typedef enum logic [3:0] {
		S_IDLE, S_CLEAR, S_POWER,
		S_KEY_H1, S_KEY_G1, S_KEY_M, S_KEY_G2, S_KEY_H2, S_KEY_G3,
		S_ADDR_M, S_ADDR_G, S_FUSE, S_FUSE_G
	} spfp_state_e;

endpackage

// ---- logic/spfp_tmr_if.sv ----
`timescale 1ns/1ps
interface spfp_tmr_if;
	logic        start;   // load a new duration
	logic [15:0] dur;     // duration in microsecond ticks
	logic        expire;  // one-cycle pulse when the duration has run out

	modport ctl (output start, output dur, input expire);
	modport tmr (input start, input dur, output expire);
endinterface

// ---- logic/spfp_timer.sv ----
`timescale 1ns/1ps
module spfp_timer
	import spfp_pkg::*;
#(
	parameter int TICK_CYC_P = TICK_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// timer port
	spfp_tmr_if.tmr  t
);

	logic [7:0]  div_r;
	logic [15:0] cnt_r;
	logic        expire_r;
	logic        tick;

	// ----------------------------------------------------------------
	// microsecond enable, restarted with each load so lengths are exact
	// ----------------------------------------------------------------
	assign tick = (div_r == 8'(TICK_CYC_P - 1));

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_r <= 8'h00;
		end else if (t.start || tick || cnt_r == 16'h0000) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// tick counter and expiry pulse
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 16'h0000;
		end else if (t.start) begin
			cnt_r <= t.dur;
		end else if (tick && cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			expire_r <= 1'b0;
		end else begin
			expire_r <= tick && !t.start && cnt_r == 16'h0001;
		end
	end

	assign t.expire = expire_r;

endmodule

// ---- logic/spfp_prog.sv ----
`timescale 1ns/1ps
// What this block does
// - supply driven at zero, hold_level, count_level or key_fuse_level.
// - each set bit gets its own sequence; provisional bits never see zero.
// - provisional and permanent sequences equal except the closing fuse pulse.
// - off time between pulses at least 20 us.
// - enable and address pulses last at least 20 us.
// - fuse pulse at least 100 us, 300 us typical.
// - sequence is enable keying, address pulses, then fuse pulse if permanent.
// - zero between permanent sequences; hold_level between provisional ones; here every command, try included, starts at zero in S_CLEAR.
// - unset bits read zero; never blow a zero bit.
// - provisional try sends one sequence with address count equal to the value.
// - permanent bit n uses address n, weight 2^(n-1).
// - keying: short high, count pulse, short high, no interruption.
// - lock bit at address 32 is fused after all code bits; here MODE_LOCK fuses it whenever commanded, unchecked.
module spfp_prog
	import spfp_pkg::*;
#(
	parameter int FUSE_US  = FUSE_TYP_US,  // fuse pulse length
	parameter int CLR_US   = CLEAR_US,     // zero-volt clearing time
	parameter int TICK_P   = TICK_CYC      // core_clk cycles per microsecond tick
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// user command port
	input  wire logic              cmd_valid,
	input  wire logic [1:0]        cmd_mode,
	input  wire logic [CODE_W-1:0] cmd_value,
	output logic                   cmd_ready,
	output logic                   done,
	output logic                   lock_sent,
	// supply pin driver
	output logic [1:0]             supply_lvl
);

	localparam logic [15:0] FUSE_DUR  = 16'(FUSE_US + RISE_MAX_US);
	localparam logic [15:0] CLEAR_DUR = 16'(CLR_US);
	// least lengths in cycles at this tick rate, for the waveform checks
	localparam logic [15:0] PULSE_MIN_L = 16'(SHORT_US * TICK_P);
	localparam logic [15:0] GAP_MIN_L   = 16'(GAP_US * TICK_P);
	localparam logic [15:0] FUSE_MIN_L  = 16'(FUSE_MIN_US * TICK_P);

	spfp_tmr_if tmr ();

	spfp_state_e       state_r, state_nxt;
	logic [1:0]        mode_r;
	logic [CODE_W-1:0] bits_r;
	logic [CODE_W-1:0] rem_bits;
	logic [ADDR_W-1:0] target_r;
	logic [ADDR_W-1:0] left_r;
	logic [1:0]        lvl_r;
	logic [15:0]       dur_r;
	logic              start_r;
	logic              ready_r;
	logic              done_r;
	logic              lock_r;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// address of the lowest set bit, bit k has address k+1, zero if none
	function automatic logic [ADDR_W-1:0] low_addr(input logic [CODE_W-1:0] v);
		logic [ADDR_W-1:0] a;
		a = '0;
		for (int k = CODE_W - 1; k >= 0; k--) begin
			if (v[k]) begin
				a = ADDR_W'(k + 1);
			end
		end
		return a;
	endfunction

	// bit mask of the code bit that an address selects
	function automatic logic [CODE_W-1:0] addr_mask(input logic [ADDR_W-1:0] a);
		logic [CODE_W-1:0] m;
		m = '0;
		for (int k = 0; k < CODE_W; k++) begin
			if (a == ADDR_W'(k + 1)) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction

	// supply level held in each state
	function automatic logic [1:0] lvl_of(input spfp_state_e s, input logic [1:0] m);
		case (s)
			S_CLEAR:                      return LVL_OFF;
			S_KEY_H1, S_KEY_H2, S_FUSE:   return LVL_KEY_FUSE;
			S_KEY_M, S_ADDR_M:            return LVL_COUNT;
			S_IDLE:                       return (m == MODE_TRY) ? LVL_HOLD : LVL_OFF;
			default:                      return LVL_HOLD;
		endcase
	endfunction

	// time spent in each state, in microsecond ticks
	function automatic logic [15:0] dur_of(input spfp_state_e s);
		case (s)
			S_CLEAR:                                   return CLEAR_DUR;
			S_FUSE:                                    return FUSE_DUR;
			S_KEY_H1, S_KEY_M, S_KEY_H2, S_ADDR_M:     return PULSE_DUR;
			default:                                   return GAP_DUR;
		endcase
	endfunction

	assign rem_bits = bits_r & ~addr_mask(target_r);

	// ----------------------------------------------------------------
	// sequence state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (cmd_valid) begin
					state_nxt = S_CLEAR;  // every command starts from a cleared device
				end
			end
			S_CLEAR:  if (tmr.expire) state_nxt = S_POWER;
			S_POWER: begin
				if (tmr.expire) begin
					state_nxt = (target_r == '0) ? S_IDLE : S_KEY_H1;
				end
			end
			// keying: short high, count pulse, short high, supply held
			S_KEY_H1: if (tmr.expire) state_nxt = S_KEY_G1;
			S_KEY_G1: if (tmr.expire) state_nxt = S_KEY_M;
			S_KEY_M:  if (tmr.expire) state_nxt = S_KEY_G2;
			S_KEY_G2: if (tmr.expire) state_nxt = S_KEY_H2;
			S_KEY_H2: if (tmr.expire) state_nxt = S_KEY_G3;
			S_KEY_G3: if (tmr.expire) state_nxt = S_ADDR_M;
			S_ADDR_M: if (tmr.expire) state_nxt = S_ADDR_G;
			S_ADDR_G: begin
				if (tmr.expire) begin
					if (left_r != '0) begin
						state_nxt = S_ADDR_M;
					end else if (mode_r != MODE_TRY) begin
						state_nxt = S_FUSE;    // only permanent setting closes with a fuse pulse
					end else begin
						state_nxt = S_IDLE;    // provisional code stays at hold_level
					end
				end
			end
			S_FUSE:   if (tmr.expire) state_nxt = S_FUSE_G;
			S_FUSE_G: begin
				if (tmr.expire) begin
					// next set bit gets its own sequence after a drop to zero
					state_nxt = (mode_r != MODE_LOCK && rem_bits != '0) ? S_CLEAR : S_IDLE;
				end
			end
			default:  state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// command capture and bitfield address selection
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mode_r   <= MODE_BURN;
			bits_r   <= '0;
			target_r <= '0;
		end else if (state_r == S_IDLE && cmd_valid) begin
			mode_r <= cmd_mode;
			bits_r <= cmd_value;
			case (cmd_mode)
				MODE_TRY:  target_r <= {1'b0, cmd_value};    // whole value as a pulse count
				MODE_LOCK: target_r <= ADDR_LOCK;
				default:   target_r <= low_addr(cmd_value);  // only set bits, weight 2^(n-1)
			endcase
		end else if (state_r == S_FUSE_G && state_nxt == S_CLEAR) begin
			bits_r   <= rem_bits;
			target_r <= low_addr(rem_bits);
		end
	end

	// address pulses still to send after the current one
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			left_r <= '0;
		end else if (state_nxt == S_ADDR_M && state_r == S_KEY_G3) begin
			left_r <= target_r - ADDR_W'(1);
		end else if (state_nxt == S_ADDR_M && state_r == S_ADDR_G) begin
			left_r <= left_r - ADDR_W'(1);  // one count_level pulse per address step
		end
	end

	// ----------------------------------------------------------------
	// supply level on each state change, timer load on each one except into S_IDLE
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lvl_r   <= LVL_OFF;
			dur_r   <= 16'h0000;
			start_r <= 1'b0;
		end else begin
			start_r <= (state_nxt != state_r) && (state_nxt != S_IDLE);
			if (state_nxt != state_r) begin
				lvl_r <= lvl_of(state_nxt, mode_r);
				dur_r <= dur_of(state_nxt);
			end
		end
	end

	assign tmr.start = start_r;
	assign tmr.dur   = dur_r;

	spfp_timer #(
		.TICK_CYC_P (TICK_P)
	) u_timer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.t        (tmr.tmr)
	);

	// ----------------------------------------------------------------
	// user handshake and status
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ready_r <= 1'b0;
			done_r  <= 1'b0;
			lock_r  <= 1'b0;
		end else begin
			ready_r <= (state_nxt == S_IDLE) && !(state_r == S_IDLE && cmd_valid);
			done_r  <= (state_r != S_IDLE) && (state_nxt == S_IDLE);
			if (state_r == S_FUSE_G && state_nxt == S_IDLE && mode_r == MODE_LOCK) begin
				lock_r <= 1'b1;  // device now ignores further sequences
			end
		end
	end

	assign cmd_ready  = ready_r;
	assign done       = done_r;
	assign lock_sent  = lock_r;
	assign supply_lvl = lvl_r;

	// ----------------------------------------------------------------
	// checks on the driven waveform
	// ----------------------------------------------------------------
	logic [15:0]       len_r;
	logic [1:0]        prev_r;
	logic [ADDR_W-1:0] mids_r;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			len_r  <= 16'h0000;
			prev_r <= LVL_OFF;
			mids_r <= '0;
		end else begin
			prev_r <= lvl_r;
			if (lvl_r != prev_r) begin
				len_r <= 16'h0001;
			end else if (len_r != 16'hffff) begin
				len_r <= len_r + 16'h0001;
			end
			if (state_r == S_KEY_G3) begin
				mids_r <= '0;
			end else if (state_r == S_ADDR_G && $past(state_r) == S_ADDR_M) begin
				mids_r <= mids_r + ADDR_W'(1);
			end
		end
	end

	pulse_width_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(lvl_r != prev_r && (prev_r == LVL_COUNT || prev_r == LVL_KEY_FUSE)) |-> len_r >= PULSE_MIN_L)
		else $error("pulse shorter than the least pulse time");

	gap_width_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(prev_r == LVL_HOLD && (lvl_r == LVL_COUNT || lvl_r == LVL_KEY_FUSE)) |-> len_r >= GAP_MIN_L)
		else $error("gap before pulse too short");

	fuse_width_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r == S_FUSE_G && $past(state_r) == S_FUSE) |-> len_r >= FUSE_MIN_L)
		else $error("fuse pulse too short");

	fuse_perm_only_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r == S_FUSE) |-> (mode_r != MODE_TRY && lvl_r == LVL_KEY_FUSE))
		else $error("fuse pulse in a provisional sequence");

	key_before_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(state_r == S_ADDR_M) |-> ($past(state_r) == S_KEY_G3 || $past(state_r) == S_ADDR_G))
		else $error("address pulse without keying");

	addr_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r == S_ADDR_G && state_nxt != S_ADDR_G && state_nxt != S_ADDR_M) |=> mids_r == target_r)
		else $error("address pulse count differs from target");

	zero_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r == S_FUSE && mode_r != MODE_LOCK) |-> (addr_mask(target_r) & bits_r) != '0)
		else $error("fuse pulse for a zero bit");

	lock_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r == S_FUSE && mode_r == MODE_LOCK) |-> target_r == ADDR_LOCK)
		else $error("lock fused at wrong address");

	no_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r != S_IDLE && state_r != S_CLEAR && (mode_r == MODE_TRY || state_nxt != S_IDLE))
		|-> ##1 (state_r == S_CLEAR || lvl_r != LVL_OFF))
		else $error("supply dropped inside a sequence");

	try_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_r == S_KEY_G3 && mode_r == MODE_TRY) |-> target_r == {1'b0, bits_r})
		else $error("provisional count differs from value");

endmodule

// ---- tb/spfp_dev_model.sv ----
`timescale 1ns/1ps
module spfp_dev_model
	import spfp_pkg::*;
#(
	parameter int TICK_P = TICK_CYC  // core_clk cycles per microsecond
) (
	// clock and supply pin
	input  wire logic              core_clk,
	input  wire logic [1:0]        supply_lvl,
	// observed device state
	output logic [CODE_W-1:0]      code,
	output logic                   locked,
	output int                     viol
);
	logic [1:0]        prev_r = LVL_OFF;
	logic [15:0]       run_r  = 16'h0;
	logic [1:0]        key_r  = 2'h0;
	logic [ADDR_W-1:0] addr_r = 6'h0;
	logic [CODE_W-1:0] prov_r = 5'h0;
	logic [CODE_W-1:0] fuse_r = 5'h0;
	logic              lock_r = 1'b0;
	int                viol_r = 0;

	// least lengths in cycles at the bench tick rate
	localparam logic [15:0] PULSE_MIN_L = 16'(SHORT_US * TICK_P);
	localparam logic [15:0] GAP_MIN_L   = 16'(GAP_US * TICK_P);
	localparam logic [15:0] FUSE_MIN_L  = 16'(FUSE_MIN_US * TICK_P);

	// sensed operate code; release point follows at a fixed offset, so only this is kept
	assign code   = prov_r | fuse_r;
	assign locked = lock_r;
	assign viol   = viol_r;

	// ----------------------------------------------------------------
	// pulse decoder, judged when each level segment ends
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		prev_r <= supply_lvl;
		if (supply_lvl != prev_r)
			run_r <= 16'h1;
		else if (run_r != 16'hffff)
			run_r <= run_r + 16'h1;
		if (supply_lvl == LVL_OFF) begin
			key_r  <= 2'h0;
			addr_r <= 6'h0;
			prov_r <= 5'h0;
		end else if (supply_lvl != prev_r && prev_r == LVL_HOLD) begin
			if (run_r < GAP_MIN_L)
				viol_r <= viol_r + 1;
		end else if (supply_lvl == LVL_HOLD && prev_r != LVL_HOLD && prev_r != LVL_OFF) begin
			if (run_r < PULSE_MIN_L)
				viol_r <= viol_r + 1;
			if (!lock_r) begin
				if (prev_r == LVL_COUNT) begin
					if (key_r == 2'h1)
						key_r <= 2'h2;
					else if (key_r == 2'h3) begin
						addr_r <= addr_r + 6'h1;
						if (addr_r < 6'h1f)
							prov_r <= CODE_W'(addr_r + 6'h1);
					end else
						key_r <= 2'h0;
				end else if (run_r < FUSE_MIN_L) begin
					// short high: keying step or separator
					if (key_r == 2'h0)
						key_r <= 2'h1;
					else if (key_r == 2'h2)
						key_r <= 2'h3;
					else if (key_r == 2'h1)
						key_r <= 2'h0;
				end else if (key_r == 2'h3) begin
					if (addr_r == ADDR_LOCK)
						lock_r <= 1'b1;
					else if (addr_r != 6'h0 && addr_r <= 6'h5)
						fuse_r[addr_r - 6'h1] <= 1'b1;
				end
			end
		end
	end
endmodule

// ---- tb/test_supply_pulse_fuse_programmer.sv ----
`timescale 1ns/1ps
module test_supply_pulse_fuse_programmer import spfp_pkg::*;;
	// state noted at each done: lock_sent, level, code, lock fuse
	typedef logic [8:0] spfp_exp_t;

	logic              core_clk;
	logic              nrst;
	logic              cmd_valid;
	logic [1:0]        cmd_mode;
	logic [CODE_W-1:0] cmd_value;
	logic              cmd_ready;
	logic              done;
	logic              lock_sent;
	logic [1:0]        supply_lvl;
	logic [CODE_W-1:0] dev_code;
	logic              dev_locked;
	int                dev_viol;
	int                error_cnt = 0;
	int                checks    = 0;
	logic [16:0]       lfsr      = 17'h12d5c;
	spfp_exp_t         exp_q[$];
	logic [2:0]        seen_hi;

	// ----------------------------------------------------------------
	// design and device model
	// ----------------------------------------------------------------
	// short tick keeps the run short; clear outlasts the busy check
	spfp_prog #(.FUSE_US(100), .CLR_US(20), .TICK_P(8)) u_spfp_prog (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.cmd_valid  (cmd_valid),
		.cmd_mode   (cmd_mode),
		.cmd_value  (cmd_value),
		.cmd_ready  (cmd_ready),
		.done       (done),
		.lock_sent  (lock_sent),
		.supply_lvl (supply_lvl)
	);

	spfp_dev_model #(.TICK_P(8)) u_spfp_dev_model (
		.core_clk   (core_clk),
		.supply_lvl (supply_lvl),
		.code       (dev_code),
		.locked     (dev_locked),
		.viol       (dev_viol)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] expv);
		checks++;
		if (seen !== expv) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, expv, seen);
		end
	endtask

	task stop_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one command: take, random noise while busy, wait for idle
	task automatic run_cmd(input logic [1:0] mode, input logic [4:0] value, input spfp_exp_t expv);
		int n;
		cmd_valid = 1'b1;
		cmd_mode  = mode;
		cmd_value = value;
		exp_q.push_back(expv);
		@(posedge core_clk);
		#1;
		repeat (100) begin
			lfsr = lfsr_next(lfsr);
			cmd_mode  = lfsr[1:0];
			cmd_value = lfsr[6:2];
			@(posedge core_clk);
			#1;
		end
		check("busy_clear", {6'h0, cmd_ready, supply_lvl}, {7'h0, LVL_OFF});
		cmd_valid = 1'b0;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 300000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("ready_wait", {8'h0, cmd_ready}, 9'h001);
	endtask

	// clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// result watcher: compares device state with the oldest note at each done
	initial begin
		forever begin
			@(posedge core_clk);
			#1;
			if (done === 1'b1) begin
				seen_hi = {lock_sent, supply_lvl};
				// the device model sees the final supply level one edge later
				@(posedge core_clk);
				#1;
				if (exp_q.size() == 0)
					check("extra_done", 9'h1, 9'h0);
				else
					check("state", {seen_hi, dev_code, dev_locked}, exp_q.pop_front());
			end
		end
	end

	// watchdog
	initial begin
		#2400000;
		error_cnt++;
		$display("unexpected watchdog: expected done seen hang");
		stop_test;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		nrst      = 1'b0;
		cmd_valid = 1'b0;
		cmd_mode  = MODE_TRY;
		cmd_value = 5'h0;
		repeat (3) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		@(posedge core_clk);
		#1;
		run_cmd(MODE_TRY, 5'h01, {1'b0, LVL_HOLD, 5'h01, 1'b0});
		run_cmd(MODE_BURN, 5'h05, {1'b0, LVL_OFF, 5'h05, 1'b0});
		run_cmd(MODE_LOCK, lfsr[4:0], {1'b1, LVL_OFF, 5'h05, 1'b1});
		run_cmd(MODE_TRY, 5'h02, {1'b1, LVL_HOLD, 5'h05, 1'b1});
		repeat (5) @(posedge core_clk);
		#1;
		check("pending", 9'(exp_q.size()), 9'h0);
		check("timing", 9'(dev_viol), 9'h0);
		stop_test;
	end
endmodule
